// *** hw/cmp_consts.vh ***
// Notes on behaviour
// - Guarding off per node until entry enables it.
// - Entry holds enable, interval, life time factor.
// - Guard request once per interval in milliseconds.
// - Fail after life-factor consecutive missing answers.
// - Status packed one bit per slave, eight per byte.
// - Bit 0 is node 1, bit 7 node 8.
// - Bit is 1 only when enabled and answering.
// - Status byte at configurable input image position.
// - Queue ten emergencies, only from guarded nodes.
// - Pending counter rises as message is queued.
// - Present message, counter and sender at positions.
// - Control byte: bit7 emcy, bit6 run, bit5 RTR.
// - Emcy toggle pops next; counter down unless zero.
// - Run toggle change sends set-operational command.
// - RTR rising edge requests all receive PDOs.
// - Error byte at configurable input image position.
// - SDO records at configured request/response offsets.
// - Master starts SDO; done when job numbers match.
// - Request: index, sub, cmd, job, node, len, data.
// - Command 1 read, 2 write, else unsupported.
// - Response length is actual length when it fits.
// - Longer received data is cut to requested length.
`ifndef CMP_CONSTS_VH
`define CMP_CONSTS_VH

`define CMP_CLK_PERIOD_PS   8000
`define CMP_MS_PS           1000000000
`define CMP_MS_CYCLES       (`CMP_MS_PS / `CMP_CLK_PERIOD_PS)

`define CMP_REG_STATUS_POS  8'h00
`define CMP_REG_EMCY_CNT    8'h04
`define CMP_REG_EMCY_NODE   8'h08
`define CMP_REG_EMCY_DATA   8'h0c
`define CMP_REG_ERROR_POS   8'h10
`define CMP_REG_CTRL_POS    8'h14
`define CMP_REG_SDO_REQ     8'h18
`define CMP_REG_SDO_RSP     8'h1c
`define CMP_REG_STATE       8'h20
`define CMP_REG_GUARD0      8'h40

`define CMP_GRD_EN_BIT      31
`define CMP_GRD_LIFE_HI     23
`define CMP_GRD_LIFE_LO     16

`define CMP_CTRL_EMCY_BIT   7
`define CMP_CTRL_RUN_BIT    6
`define CMP_CTRL_RTR_BIT    5

`define CMP_SDO_CMD_READ    8'h01
`define CMP_SDO_CMD_WRITE   8'h02
`define CMP_SDO_UNSUPPORTED 8'hff
`define CMP_SDO_HDR_LEN     8'h07

`define CMP_ERR_FAIL_BIT    0
`define CMP_ERR_DROP_BIT    1
`define CMP_ERR_SDO_BIT     2

`endif

// *** hw/cmp_emcy_queue.v ***
`timescale 1ns/1ps
module cmp_emcy_queue #(
    parameter DEPTH = 10,
    parameter WIDTH = 71
) (
    input  wire             mclk,
    input  wire             reset_n,
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    input  wire             pop,
    output wire [WIDTH-1:0] head,
    output wire             empty,
    output wire             full,
    output reg  [3:0]       count
);
    reg [WIDTH-1:0] slot [0:DEPTH-1];
    reg [3:0]       rd_ptr;
    reg [3:0]       wr_ptr;
    wire            do_push;
    wire            do_pop;

    assign empty   = (count == 4'h0);
    assign full    = (count == DEPTH[3:0]);
    assign head    = slot[rd_ptr];
    // A push into a full queue is dropped whole.
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;

    always @(posedge mclk) begin
        if (do_push) begin
            slot[wr_ptr] <= push_data;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_ptr <= 4'h0;
            wr_ptr <= 4'h0;
            count  <= 4'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == DEPTH[3:0] - 4'h1) ? 4'h0 : wr_ptr + 4'h1;
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == DEPTH[3:0] - 4'h1) ? 4'h0 : rd_ptr + 4'h1;
            end
            // Counter rises with the push and falls only when not zero.
            if (do_push && !do_pop) begin
                count <= count + 4'h1;
            end else if (do_pop && !do_push) begin
                count <= count - 4'h1;
            end
        end
    end
endmodule

// *** hw/cmp_gateway.v ***
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
`include "cmp_consts.vh"
module cmp_gateway #(
    parameter NODES      = 8,
    parameter MS_CYCLES  = `CMP_MS_CYCLES,
    parameter EMCY_DEPTH = 10,
    parameter SDO_BYTES  = 4
) (
    input  wire        mclk,
    input  wire        reset_n,
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire        pb_wr,
    input  wire [7:0]  pb_wr_addr,
    input  wire [7:0]  pb_wdata,
    input  wire [7:0]  pb_rd_addr,
    output reg  [7:0]  pb_rdata,
    input  wire [7:0]  guard_answer,
    output reg  [7:0]  guard_request,
    input  wire        emcy_valid,
    input  wire [6:0]  emcy_node,
    input  wire [63:0] emcy_data,
    output reg         nmt_run_cmd,
    output reg         rtr_request,
    output reg         sdo_start,
    output reg  [15:0] sdo_index,
    output reg  [7:0]  sdo_subindex,
    output reg         sdo_is_write,
    output reg  [6:0]  sdo_node,
    output reg  [31:0] sdo_wdata,
    input  wire        sdo_done,
    input  wire [7:0]  sdo_status,
    input  wire [7:0]  sdo_rx_len,
    input  wire [31:0] sdo_rx_data
);
    reg  [7:0]  status_pos;
    reg  [7:0]  emcy_cnt_pos;
    reg  [7:0]  emcy_node_pos;
    reg  [7:0]  emcy_data_pos;
    reg  [7:0]  error_pos;
    reg  [7:0]  ctrl_pos;
    reg  [7:0]  sdo_request_offset;
    reg  [7:0]  sdo_response_offset;
    reg  [31:0] guard_cfg [0:NODES-1];
    reg  [7:0]  guard_ok;
    reg  [7:0]  guard_failed;
    reg  [2:0]  err_flags;
    reg  [7:0]  ctrl_prev;
    reg  [63:0] emcy_cur_data;
    reg  [6:0]  emcy_cur_node;
    reg  [7:0]  req_byte [0:6];
    reg  [31:0] req_data;
    reg  [7:0]  rsp_status;
    reg  [7:0]  rsp_job;
    reg  [7:0]  rsp_len;
    reg  [31:0] rsp_data;
    reg  [16:0] ms_count;
    reg         ms_tick;
    reg  [31:0] next_readdata;
    reg  [7:0]  next_pb_rdata;
    reg  [7:0]  rel;
    wire        bus_req;
    wire        bus_wr;
    wire [7:0]  status_byte;
    wire [7:0]  error_byte;
    wire [70:0] emcy_head;
    wire [3:0]  emcy_count;
    wire        emcy_full;
    wire        emcy_empty;
    wire        emcy_accept;
    wire        ctrl_wr;
    wire [7:0]  ctrl_chg;
    wire        emcy_pop;
    wire [7:0]  sdo_rel;
    wire        sdo_job_wr;
    wire        sdo_cmd_ok;
    integer     i;

    // One wait cycle on every access; the slave answers at the second edge.
    assign bus_req = avs_read || avs_write;
    assign bus_wr  = avs_write && !avs_waitrequest;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !(bus_req && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    always @* begin
        next_readdata = 32'h0000_0000;
        if (avs_address == `CMP_REG_STATUS_POS) begin
            next_readdata = {24'h00_0000, status_pos};
        end else if (avs_address == `CMP_REG_EMCY_CNT) begin
            next_readdata = {24'h00_0000, emcy_cnt_pos};
        end else if (avs_address == `CMP_REG_EMCY_NODE) begin
            next_readdata = {24'h00_0000, emcy_node_pos};
        end else if (avs_address == `CMP_REG_EMCY_DATA) begin
            next_readdata = {24'h00_0000, emcy_data_pos};
        end else if (avs_address == `CMP_REG_ERROR_POS) begin
            next_readdata = {24'h00_0000, error_pos};
        end else if (avs_address == `CMP_REG_CTRL_POS) begin
            next_readdata = {24'h00_0000, ctrl_pos};
        end else if (avs_address == `CMP_REG_SDO_REQ) begin
            next_readdata = {24'h00_0000, sdo_request_offset};
        end else if (avs_address == `CMP_REG_SDO_RSP) begin
            next_readdata = {24'h00_0000, sdo_response_offset};
        end else if (avs_address == `CMP_REG_STATE) begin
            next_readdata = {12'h000, emcy_count, error_byte, status_byte};
        end else if (avs_address >= `CMP_REG_GUARD0 &&
                     avs_address < `CMP_REG_GUARD0 + 8'h20 &&
                     avs_address[1:0] == 2'b00) begin
            next_readdata = guard_cfg[avs_address[4:2]];
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            status_pos          <= 8'h00;
            emcy_cnt_pos        <= 8'h01;
            emcy_node_pos       <= 8'h02;
            emcy_data_pos       <= 8'h03;
            error_pos           <= 8'h0b;
            ctrl_pos            <= 8'h00;
            sdo_request_offset  <= 8'h08;
            sdo_response_offset <= 8'h0c;
            for (i = 0; i < NODES; i = i + 1) begin
                guard_cfg[i] <= 32'h0000_0000;
            end
        end else if (bus_wr) begin
            if (avs_address == `CMP_REG_STATUS_POS) begin
                status_pos <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_EMCY_CNT) begin
                emcy_cnt_pos <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_EMCY_NODE) begin
                emcy_node_pos <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_EMCY_DATA) begin
                emcy_data_pos <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_ERROR_POS) begin
                error_pos <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_CTRL_POS) begin
                ctrl_pos <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_SDO_REQ) begin
                sdo_request_offset <= avs_writedata[7:0];
            end else if (avs_address == `CMP_REG_SDO_RSP) begin
                sdo_response_offset <= avs_writedata[7:0];
            end else if (avs_address >= `CMP_REG_GUARD0 &&
                         avs_address < `CMP_REG_GUARD0 + 8'h20 &&
                         avs_address[1:0] == 2'b00) begin
                guard_cfg[avs_address[4:2]] <= avs_writedata;
            end
        end
    end

    // Shared millisecond tick keeps the per-node timers narrow.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ms_count <= 17'h0_0000;
            ms_tick  <= 1'b0;
        end else begin
            ms_tick <= (ms_count == MS_CYCLES[16:0] - 17'h0_0001);
            if (ms_count == MS_CYCLES[16:0] - 17'h0_0001) begin
                ms_count <= 17'h0_0000;
            end else begin
                ms_count <= ms_count + 17'h0_0001;
            end
        end
    end

    genvar n;
    generate
        for (n = 0; n < NODES; n = n + 1) begin : g_guard
            reg  [15:0] ms_left;
            reg  [7:0]  missed;
            reg         answered;
            wire        enabled;
            wire        due;
            assign enabled = guard_cfg[n][`CMP_GRD_EN_BIT];
            assign due     = enabled && ms_tick && (ms_left <= 16'h0001);
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    ms_left             <= 16'h0000;
                    missed              <= 8'h00;
                    answered            <= 1'b0;
                    guard_ok[n]         <= 1'b0;
                    guard_failed[n]     <= 1'b0;
                    guard_request[n]    <= 1'b0;
                end else if (!enabled) begin
                    ms_left             <= guard_cfg[n][15:0];
                    missed              <= 8'h00;
                    answered            <= 1'b1;
                    guard_ok[n]         <= 1'b0;
                    guard_failed[n]     <= 1'b0;
                    guard_request[n]    <= 1'b0;
                end else begin
                    guard_request[n] <= due;
                    if (ms_tick) begin
                        ms_left <= due ? guard_cfg[n][15:0]
                                       : ms_left - 16'h0001;
                    end
                    // An answer in the same cycle as a request wins.
                    if (guard_answer[n]) begin
                        answered        <= 1'b1;
                        missed          <= 8'h00;
                        guard_ok[n]     <= 1'b1;
                        guard_failed[n] <= 1'b0;
                    end else if (due) begin
                        answered <= 1'b0;
                        if (!answered) begin
                            missed <= missed + 8'h01;
                            if (missed + 8'h01 >=
                                guard_cfg[n][`CMP_GRD_LIFE_HI:
                                             `CMP_GRD_LIFE_LO]) begin
                                guard_failed[n] <= 1'b1;
                                guard_ok[n]     <= 1'b0;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // Bit k carries node k+1.
    assign status_byte = guard_ok & ~guard_failed;
    assign error_byte  = {5'b00000, err_flags};

    assign emcy_accept = emcy_valid && emcy_node != 7'h00 &&
                         emcy_node <= NODES[6:0] &&
                         guard_cfg[emcy_node[2:0] - 3'h1][`CMP_GRD_EN_BIT];

    assign ctrl_wr  = pb_wr && pb_wr_addr == ctrl_pos;
    assign ctrl_chg = ctrl_wr ? (pb_wdata ^ ctrl_prev) : 8'h00;
    assign emcy_pop = ctrl_chg[`CMP_CTRL_EMCY_BIT];

    cmp_emcy_queue #(
        .DEPTH     (EMCY_DEPTH),
        .WIDTH     (71)
    ) u_queue (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .push      (emcy_accept),
        .push_data ({emcy_node, emcy_data}),
        .pop       (emcy_pop),
        .head      (emcy_head),
        .empty     (emcy_empty),
        .full      (emcy_full),
        .count     (emcy_count)
    );

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_prev     <= 8'h00;
            emcy_cur_data <= 64'h0;
            emcy_cur_node <= 7'h00;
            nmt_run_cmd   <= 1'b0;
            rtr_request   <= 1'b0;
            err_flags     <= 3'b000;
        end else begin
            if (ctrl_wr) begin
                ctrl_prev <= pb_wdata;
            end
            if (emcy_pop && !emcy_empty) begin
                emcy_cur_data <= emcy_head[63:0];
                emcy_cur_node <= emcy_head[70:64];
            end
            nmt_run_cmd <= ctrl_chg[`CMP_CTRL_RUN_BIT];
            rtr_request <= ctrl_chg[`CMP_CTRL_RTR_BIT] &&
                           pb_wdata[`CMP_CTRL_RTR_BIT];
            err_flags[`CMP_ERR_FAIL_BIT] <= |guard_failed;
            if (emcy_accept && emcy_full) begin
                err_flags[`CMP_ERR_DROP_BIT] <= 1'b1;
            end
            if (sdo_job_wr && !sdo_cmd_ok) begin
                err_flags[`CMP_ERR_SDO_BIT] <= 1'b1;
            end else if (sdo_job_wr) begin
                err_flags[`CMP_ERR_SDO_BIT] <= 1'b0;
            end
        end
    end

    // Writing the job number byte launches the request.
    assign sdo_rel    = pb_wr_addr - sdo_request_offset;
    assign sdo_job_wr = pb_wr && pb_wr_addr >= sdo_request_offset &&
                        sdo_rel == 8'h04;
    assign sdo_cmd_ok = req_byte[3] == `CMP_SDO_CMD_READ ||
                        req_byte[3] == `CMP_SDO_CMD_WRITE;

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (i = 0; i < 7; i = i + 1) begin
                req_byte[i] <= 8'h00;
            end
            req_data     <= 32'h0000_0000;
            rsp_status   <= 8'h00;
            rsp_job      <= 8'h00;
            rsp_len      <= 8'h00;
            rsp_data     <= 32'h0000_0000;
            sdo_start    <= 1'b0;
            sdo_index    <= 16'h0000;
            sdo_subindex <= 8'h00;
            sdo_is_write <= 1'b0;
            sdo_node     <= 7'h00;
            sdo_wdata    <= 32'h0000_0000;
        end else begin
            sdo_start <= sdo_job_wr && sdo_cmd_ok;
            if (pb_wr && pb_wr_addr >= sdo_request_offset) begin
                if (sdo_rel < `CMP_SDO_HDR_LEN) begin
                    req_byte[sdo_rel[2:0]] <= pb_wdata;
                end else if (sdo_rel < `CMP_SDO_HDR_LEN + SDO_BYTES[7:0]) begin
                    req_data[{sdo_rel[1:0] + 2'b01, 3'b000} +: 8] <= pb_wdata;
                end
            end
            if (sdo_job_wr) begin
                sdo_index    <= {req_byte[0], req_byte[1]};
                sdo_subindex <= req_byte[2];
                sdo_is_write <= req_byte[3] == `CMP_SDO_CMD_WRITE;
                sdo_node     <= req_byte[5][6:0];
                sdo_wdata    <= req_data;
                if (!sdo_cmd_ok) begin
                    rsp_status <= `CMP_SDO_UNSUPPORTED;
                    rsp_len    <= 8'h00;
                    rsp_data   <= 32'h0000_0000;
                    rsp_job    <= pb_wdata;
                end
            end else if (sdo_done) begin
                rsp_status <= sdo_status;
                rsp_job    <= req_byte[4];
                if (sdo_rx_len <= req_byte[6]) begin
                    rsp_len <= sdo_rx_len;
                end else begin
                    rsp_len <= req_byte[6];
                end
                rsp_data <= sdo_rx_data;
            end
        end
    end

    // Input image read port: the mapped items overlay a zero image.
    always @* begin
        next_pb_rdata = 8'h00;
        rel = pb_rd_addr - sdo_response_offset;
        if (pb_rd_addr == status_pos) begin
            next_pb_rdata = status_byte;
        end else if (pb_rd_addr == error_pos) begin
            next_pb_rdata = error_byte;
        end else if (pb_rd_addr == emcy_cnt_pos) begin
            next_pb_rdata = {4'h0, emcy_count};
        end else if (pb_rd_addr == emcy_node_pos) begin
            next_pb_rdata = {1'b0, emcy_cur_node};
        end else if (pb_rd_addr >= emcy_data_pos &&
                     pb_rd_addr - emcy_data_pos < 8'h08) begin
            rel = pb_rd_addr - emcy_data_pos;
            next_pb_rdata = emcy_cur_data[{rel[2:0], 3'b000} +: 8];
        end else if (pb_rd_addr >= sdo_response_offset) begin
            if (rel == 8'h03) begin
                next_pb_rdata = rsp_status;
            end else if (rel == 8'h04) begin
                next_pb_rdata = rsp_job;
            end else if (rel == 8'h06) begin
                next_pb_rdata = rsp_len;
            end else if (rel < `CMP_SDO_HDR_LEN) begin
                next_pb_rdata = req_byte[rel[2:0]];
            end else if (rel - `CMP_SDO_HDR_LEN < rsp_len &&
                         rel < `CMP_SDO_HDR_LEN + SDO_BYTES[7:0]) begin
                next_pb_rdata = rsp_data[{rel[1:0] + 2'b01, 3'b000} +: 8];
            end
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pb_rdata <= 8'h00;
        end else begin
            pb_rdata <= next_pb_rdata;
        end
    end
endmodule

// *** dv/cmp_gateway_properties.sv ***
`timescale 1ns/1ps
module cmp_gateway_properties (
    input        mclk,
    input        reset_n,
    input [7:0]  avs_address,
    input        avs_read,
    input        avs_write,
    input [31:0] avs_writedata,
    input        avs_waitrequest,
    input        pb_wr,
    input [7:0]  pb_wr_addr,
    input [7:0]  pb_wdata,
    input [7:0]  guard_request,
    input        nmt_run_cmd,
    input        rtr_request,
    input        sdo_start,
    input [15:0] sdo_index,
    input        sdo_is_write,
    input [6:0]  sdo_node
);
    reg [7:0] img [0:15];
    reg       en_seen;
    integer   i;
    // Shadow image uses the reset positions.
    wire ctl = pb_wr && pb_wr_addr == 8'h00;
    wire run_chg = ctl && pb_wdata[6] != img[0][6];
    wire rtr_up = ctl && pb_wdata[5] && !img[0][5];
    wire launch = pb_wr && pb_wr_addr == 8'h0c
        && (img[11] == 8'h01 || img[11] == 8'h02);
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            en_seen <= 1'b0;
            for (i = 0; i < 16; i = i + 1) begin
                img[i] <= 8'h00;
            end
        end else begin
            if (pb_wr && pb_wr_addr < 8'h10) begin
                img[pb_wr_addr[3:0]] <= pb_wdata;
            end
            if (avs_write && !avs_waitrequest && avs_address[7:6] == 2'b01
                && avs_writedata[31]) begin
                en_seen <= 1'b1;
            end
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("no answer");
    a_bus_idle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer too long");
    a_guard_off: assert property (
        !en_seen |-> guard_request == 8'h00) else $error("unguarded request");
    a_guard_pulse: assert property (
        guard_request != 8'h00 |=> guard_request == 8'h00)
        else $error("guard pulse long");
    a_run_toggle: assert property (
        nmt_run_cmd == $past(run_chg)) else $error("run command wrong");
    a_rtr_edge: assert property (
        rtr_request == $past(rtr_up)) else $error("rtr request wrong");
    a_sdo_launch: assert property (
        sdo_start == $past(launch)) else $error("sdo start wrong");
    a_sdo_fields: assert property (
        sdo_start |-> sdo_index == {img[8], img[9]}
        && sdo_node == img[13][6:0] && sdo_is_write == (img[11] == 8'h02))
        else $error("sdo fields wrong");
    c_run: cover property (nmt_run_cmd);
    c_rtr: cover property (rtr_request);
    c_sdo_wr: cover property (sdo_start && sdo_is_write);
endmodule
bind cmp_gateway cmp_gateway_properties u_props (.*);

// *** dv/cmp_can_model.sv ***
`timescale 1ns/1ps
module cmp_can_model (
    input  wire        mclk,
    input  wire [7:0]  guard_request,
    input  wire [7:0]  ans_mask,
    input  wire        slow,
    input  wire        sdo_start,
    input  wire [7:0]  rx_len,
    input  wire [31:0] rx_data,
    output reg  [7:0]  guard_answer = 8'h00,
    output reg         sdo_done = 1'b0,
    output reg  [7:0]  sdo_status = 8'hff,
    output reg  [7:0]  sdo_rx_len = 8'h00,
    output reg  [31:0] sdo_rx_data = 32'h0
);
    reg [7:0] pend;
    always @(posedge mclk) begin
        if (guard_request != 8'h00) begin
            pend <= guard_request & ans_mask;
            repeat (slow ? 4 : 1) @(posedge mclk);
            guard_answer <= pend;
            @(posedge mclk);
            guard_answer <= 8'h00;
        end
    end
    always @(posedge mclk) begin
        if (sdo_start) begin
            repeat (slow ? 6 : 1) @(posedge mclk);
            sdo_done <= 1'b1;
            sdo_status <= 8'h00;
            sdo_rx_len <= rx_len;
            sdo_rx_data <= rx_data;
            @(posedge mclk);
            sdo_done <= 1'b0;
            sdo_status <= 8'hff;
            sdo_rx_len <= ~rx_len;
            sdo_rx_data <= ~rx_data;
        end
    end
endmodule

// *** dv/cmp_gateway_tb_top.sv ***
`timescale 1ns/1ps
module cmp_gateway_tb_top;
    reg         mclk = 1'b0, reset_n = 1'b0, slow = 1'b1;
    reg         avs_read = 1'b0, avs_write = 1'b0, pb_wr = 1'b0;
    reg         emcy_valid = 1'b0;
    reg  [7:0]  avs_address = 8'h00, pb_wr_addr = 8'h00, pb_wdata = 8'h00;
    reg  [7:0]  pb_rd_addr = 8'h00, ans_mask = 8'h00, rx_len = 8'h00;
    reg  [7:0]  ctrl_m = 8'h00;
    reg  [6:0]  emcy_node = 7'h00;
    reg  [31:0] avs_writedata = 32'h0, rx_data = 32'h0, r;
    reg  [63:0] emcy_data = 64'h0, cur, q[$];
    wire [31:0] avs_readdata, sdo_rx_data;
    wire [7:0]  pb_rdata, guard_answer, guard_request, sdo_status, sdo_rx_len;
    wire        avs_waitrequest, nmt_run_cmd, rtr_request, sdo_start, sdo_done;
    integer     n_fail = 0, check_count = 0, cycles = 0, i, job = 0;
    integer     nmt_exp = 0, rtr_exp = 0, nmt_seen = 0, rtr_seen = 0;
    integer     seed = 32'hf7192f7a;
    cmp_gateway #(.MS_CYCLES(10)) dut (.*, .sdo_index(), .sdo_subindex(),
        .sdo_is_write(), .sdo_node(), .sdo_wdata());
    cmp_can_model can (.*);
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles = cycles + 1;
        nmt_seen = nmt_seen + (nmt_run_cmd === 1'b1);
        rtr_seen = rtr_seen + (rtr_request === 1'b1);
        if (cycles == 8000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string w, input [31:0] e, g);
        check_count = check_count + 1;
        if (g !== e) begin
            n_fail = n_fail + 1;
            $display("[FAIL] %s expected %h seen %h", w, e, g);
        end
    endtask
    task av(input w, input [7:0] a, input [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task rdi(input [7:0] a);
        @(posedge mclk);
        pb_rd_addr <= a;
        repeat (2) @(posedge mclk);
        r = pb_rdata;
    endtask
    task ck(input string w, input [7:0] a, e);
        rdi(a);
        chk(w, e, r);
    endtask
    task pbw(input [7:0] a, input [7:0] d);
        @(posedge mclk);
        pb_wr <= 1'b1;
        pb_wr_addr <= a;
        pb_wdata <= d;
        @(posedge mclk);
        pb_wr <= 1'b0;
    endtask
    task ctl(input [7:0] d);
        nmt_exp = nmt_exp + (d[6] != ctrl_m[6]);
        rtr_exp = rtr_exp + (d[5] && !ctrl_m[5]);
        if (d[7] != ctrl_m[7] && q.size() > 0) cur = q.pop_front();
        ctrl_m = d;
        pbw(8'h00, d);
        repeat (2) @(posedge mclk);
    endtask
    task emcy(input [6:0] n);
        reg [63:0] d;
        d = {$random(seed), $random(seed)};
        if (n == 2 && q.size() < 10) q.push_back(d);
        @(posedge mclk);
        emcy_valid <= 1'b1;
        emcy_node <= n;
        emcy_data <= d;
        @(posedge mclk);
        emcy_valid <= 1'b0;
        emcy_data <= ~d;
    endtask
    task sdo(input [7:0] cmd, input [7:0] len, input [7:0] rl);
        integer k, n;
        job = job + 1;
        n = rl < len ? rl : len;
        rx_len <= rl;
        rx_data <= $random(seed);
        slow <= $random(seed);
        for (k = 0; k < 4; k = k + 1) pbw(8'h0f + k, $random(seed));
        pbw(8'h08, 8'h10);
        pbw(8'h09, 8'h09);
        pbw(8'h0a, 8'h00);
        pbw(8'h0b, cmd);
        pbw(8'h0d, 8'h05);
        pbw(8'h0e, len);
        pbw(8'h0c, job);
        r = 0;
        while (r !== job) rdi(8'h10);
        ck("sdo_status", 8'h0f, cmd == 1 || cmd == 2 ? 0 : 8'hff);
        if (cmd == 1 || cmd == 2) begin
            ck("sdo_index", 8'h0c, 8'h10);
            ck("sdo_len", 8'h12, n);
            for (k = 0; k < 4; k = k + 1)
                ck("sdo_data", 8'h13 + k, k < n ? rx_data[8*k+:8] : 0);
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        av(0, 8'h10, 0);
        chk("err_pos", 32'h0b, r);
        av(1, 8'h30, 32'h5a);
        av(0, 8'h30, 0);
        chk("unmapped", 0, r);
        ck("status", 8'h00, 8'h00);
        ans_mask <= 8'h02;
        av(1, 8'h40, 32'h8002_0001);
        av(1, 8'h44, 32'h8002_0001);
        repeat (80) @(posedge mclk);
        ck("status", 8'h00, 8'h02);
        ck("error", 8'h0b, 8'h01);
        $display("guarding test done");
        for (i = 0; i < 11; i = i + 1) emcy(7'd2);
        emcy(7'd3);
        ck("count", 8'h01, 8'h0a);
        ck("error", 8'h0b, 8'h03);
        for (i = 0; i < 11; i = i + 1) begin
            ctl(ctrl_m ^ 8'h80);
            ck("count", 8'h01, q.size());
            ck("emcy_data", 8'h03, cur[7:0]);
            ck("emcy_node", 8'h02, 8'h02);
        end
        $display("emergency test done");
        for (i = 0; i < 8; i = i + 1) ctl($random(seed));
        ctl(ctrl_m ^ 8'h1f);
        chk("nmt", nmt_exp, nmt_seen);
        chk("rtr", rtr_exp, rtr_seen);
        $display("control test done");
        sdo(8'h01, 8'h02, 8'h03);
        sdo(8'h02, 8'h04, 8'h04);
        sdo(8'h01, 8'h04, 8'h02);
        sdo(8'h07, 8'h02, 8'h02);
        ck("error", 8'h0b, 8'h07);
        av(1, 8'h44, 32'h0002_0001);
        ck("status", 8'h00, 8'h00);
        $display("sdo test done");
        final_report;
    end
endmodule
